// file: tb_top.sv
`default_nettype none
module tb_top
    import uvc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [3:0]  src     = 4'h0;
    logic        fault_in = 1'b0;
    logic [31:0] prdata, rv;
    logic        pready, pslverr, irq, last_err;
    logic        power_switch_out, power_switch_oe, internal_power_drive;
    logic        bus_power_charge, bus_power_discharge;
    logic        minus_line_pulldown, plus_line_pulldown, rise_event_irq;
    logic [7:0]  event_status_reg;
    logic [7:0]  pins;
    int          fail_count  = 0;
    int          comparisons = 0;
    int          rise_count  = 0;
    int          n0;

    assign pins = {1'b0, power_switch_oe, internal_power_drive, bus_power_charge,
                   bus_power_discharge, minus_line_pulldown, plus_line_pulldown, 1'b0};
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (rise_event_irq === 1'b1) rise_count++;
    end

    uvc_link_if link_bus ();
    uvc_phy_regs #(.LINK_HALF(4)) u_uvc_phy_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(link_bus),
        .session_end_cmp(src[3]), .session_valid_cmp(src[2]),
        .power_valid_cmp(src[1]), .host_disconnect_cmp(src[0]), .fault_in(fault_in),
        .power_switch_out(power_switch_out), .power_switch_oe(power_switch_oe),
        .internal_power_drive(internal_power_drive), .bus_power_charge(bus_power_charge),
        .bus_power_discharge(bus_power_discharge), .minus_line_pulldown(minus_line_pulldown),
        .plus_line_pulldown(plus_line_pulldown), .event_status_reg(event_status_reg),
        .rise_event_irq(rise_event_irq));
    uvc_link_ctrl u_uvc_link_ctrl (
        .ref_clk(ref_clk), .rst_n(rst_n), .link(link_bus), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    uvc_link_chk u_chk (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_bus.link_clk),
        .cmd_valid(link_bus.cmd_valid), .cmd_write(link_bus.cmd_write),
        .cmd_addr(link_bus.cmd_addr), .cmd_wdata(link_bus.cmd_wdata),
        .rd_valid(link_bus.rd_valid), .rd_data(link_bus.rd_data),
        .rxcmd_valid(link_bus.rxcmd_valid), .rxcmd_data(link_bus.rxcmd_data));

    // ==========
    // tasks
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one device command, result byte left in rv
    task automatic dev(input logic w, input logic [5:0] a, input logic [7:0] d);
        apb(1'b1, CMD_OFS, {1'b1, 14'h0000, w, 2'b00, a, d});
        do begin
            apb(1'b0, STATUS_OFS, 32'h0000_0000);
        end while (rv[0] !== 1'b0);
        apb(1'b1, IRQ_STAT_OFS, 32'h0000_0001);
        apb(1'b0, RDATA_OFS, 32'h0000_0000);
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        dev(1'b0, a, 8'h00);
        check(rv, {24'h00_0000, e});
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(irq), 32'h0000_0001);
    endtask

    initial begin
        repeat (30000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end

    // ==========
    // tests
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd_chk(6'h0a, OTG_RESET);
        rd_chk(6'h0d, RISE_RESET);
        check(32'(pins), 32'h0000_0006);
        apb(1'b0, 8'h18, 32'h0000_0000);
        check(32'(last_err), 32'h0000_0001);
        $display("test reset_values done");
        for (int b = 1; b < 8; b++) begin
            dev(1'b1, 6'h0a, 8'h01 << b);
            rd_chk(6'h0c, 8'h01 << b);
            check(32'(pins), 32'(8'h01 << b) & 32'h0000_007e);
        end
        check(32'(power_switch_out), 32'h0000_0000);
        dev(1'b1, 6'h0a, 8'h00);
        dev(1'b1, 6'h0b, 8'h48);
        rd_chk(6'h0a, 8'h48);
        check(32'(pins), 32'h0000_0048);
        dev(1'b1, 6'h0c, 8'h08);
        rd_chk(6'h0b, 8'h40);
        dev(1'b1, 6'h0a, 8'h06);
        $display("test control_reg done");
        dev(1'b1, 6'h0d, 8'h0a);
        rd_chk(6'h0f, 8'h0a);
        dev(1'b1, 6'h0e, 8'h05);
        rd_chk(6'h0d, 8'h0f);
        dev(1'b1, 6'h0f, 8'h03);
        rd_chk(6'h0e, 8'h0c);
        $display("test enable_reg done");
        apb(1'b1, IRQ_MASK_OFS, 32'h0000_0002);
        for (int i = 0; i < 4; i++) begin
            dev(1'b1, 6'h0d, 8'h01 << i);
            n0 = rise_count;
            src <= 4'h1 << i;
            wait_irq();
            check(32'(event_status_reg), 32'(8'h01 << i));
            check(rise_count - n0, 32'h0000_0001);
            apb(1'b0, RXCMD_OFS, 32'h0000_0000);
            check(rv, 32'(8'h11 << i));
            apb(1'b1, IRQ_STAT_OFS, 32'h0000_0002);
            @(posedge ref_clk);
            check(32'(irq), 32'h0000_0000);
            src <= 4'h0;
            repeat (20) @(posedge ref_clk);
        end
        dev(1'b1, 6'h0d, 8'h0b);
        n0 = rise_count;
        src <= 4'h4;
        repeat (60) @(posedge ref_clk);
        check(32'(irq), 32'h0000_0000);
        check(rise_count - n0, 32'h0000_0000);
        check(32'(event_status_reg), 32'h0000_0004);
        src <= 4'h0;
        $display("test rise_events done");
        dev(1'b1, 6'h0b, 8'h80);
        fault_in <= 1'b1;
        wait_irq();
        check(32'(event_status_reg), 32'h0000_0002);
        apb(1'b0, RXCMD_OFS, 32'h0000_0000);
        check(rv, 32'h0000_0022);
        $display("test external_indicator done");
        apb(1'b1, IRQ_STAT_OFS, 32'h0000_0002);
        dev(1'b1, 6'h0a, 8'h0e);
        dev(1'b1, 6'h0d, 8'h08);
        src <= 4'h8;
        wait_irq();
        apb(1'b0, RXCMD_OFS, 32'h0000_0000);
        check(rv, 32'h0000_0088);
        apb(1'b1, IRQ_STAT_OFS, 32'h0000_0002);
        dev(1'b1, 6'h0c, 8'h08);
        check(32'(pins), 32'h0000_0006);
        dev(1'b1, 6'h0b, 8'h10);
        check(32'(pins), 32'h0000_0016);
        $display("test bus_power_pulse done");
        test_done();
    end
endmodule // tb_top
`default_nettype wire

// file: uvc_link_chk.sv
`default_nettype none
module uvc_link_chk (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       link_clk,
    input wire logic       cmd_valid,
    input wire logic       cmd_write,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data,
    input wire logic       rxcmd_valid,
    input wire logic [7:0] rxcmd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ==========
    // link framing
    a_link_half_period:
        assert property ($changed(link_clk) |=> $stable(link_clk) [*3])
        else $error("link clock half period short");
    a_cmd_one_period:
        assert property ($rose(cmd_valid) |-> cmd_valid [*8] ##1 !cmd_valid)
        else $error("command not held one link period");
    a_cmd_held_stable:
        assert property (cmd_valid && $past(cmd_valid) |->
            $stable(cmd_addr) && $stable(cmd_write) && $stable(cmd_wdata))
        else $error("command changed while valid");
    a_read_gets_answer:
        assert property ($rose(cmd_valid) && !cmd_write |-> ##[1:24] $rose(rd_valid))
        else $error("read not answered");
    a_rd_on_fall:
        assert property ($rose(rd_valid) |-> $fell(link_clk))
        else $error("read answer off link fall");
    a_rd_data_stands:
        assert property ($rose(rd_valid) |=> (rd_valid && $stable(rd_data)) [*7])
        else $error("read answer not held");

    // ==========
    // event reports
    a_rx_on_fall:
        assert property ($rose(rxcmd_valid) |-> $fell(link_clk))
        else $error("report off link fall");
    a_rx_stands:
        assert property ($rose(rxcmd_valid) |-> rxcmd_valid [*8])
        else $error("report not held one period");
    a_rx_has_rise:
        assert property (rxcmd_valid |-> rxcmd_data[7:4] != 4'h0)
        else $error("report without risen source");
endmodule // uvc_link_chk
`default_nettype wire

// file: uvc_link_ctrl.sv
`default_nettype none
module uvc_link_ctrl
    import uvc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    uvc_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);

    // ========================================
    // synchronise device-driven link signals
    logic [18:0] ls1;
    logic [18:0] ls2;
    logic [18:0] ls3;
    logic        clk_lvl;

    wire [18:0] lraw = {link.link_clk, link.rd_valid, link.rd_data,
                        link.rxcmd_valid, link.rxcmd_data};
    wire rise_det = ls2[18] & ls3[18] & ~clk_lvl;
    wire fall_det = ~ls2[18] & ~ls3[18] & clk_lvl;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ls1     <= 19'h0_0000;
            ls2     <= 19'h0_0000;
            ls3     <= 19'h0_0000;
            clk_lvl <= 1'b0;
        end else begin
            ls1     <= lraw;
            ls2     <= ls1;
            ls3     <= ls2;
            clk_lvl <= (rise_det | fall_det) ? ls3[18] : clk_lvl;
        end
    end

    // ========================================
    // apb decode
    uvc_state_t  state;
    uvc_state_t  next_state;
    logic [16:0] cmd_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rxcmd_reg;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;

    wire acc       = psel & penable;
    wire wr        = acc & pwrite;
    wire hit_cmd   = (paddr == CMD_OFS);
    wire hit_rd    = (paddr == RDATA_OFS);
    wire hit_st    = (paddr == STATUS_OFS);
    wire hit_is    = (paddr == IRQ_STAT_OFS);
    wire hit_im    = (paddr == IRQ_MASK_OFS);
    wire hit_rx    = (paddr == RXCMD_OFS);
    wire mapped    = hit_cmd | hit_rd | hit_st | hit_is | hit_im | hit_rx;
    wire busy      = (state != UVC_IDLE);
    wire go        = wr & hit_cmd & pwdata[CMD_GO_BIT] & ~busy;
    wire rd_cap    = (state == UVC_WAIT_RD) & rise_det & ls2[17] & ls3[17];
    wire wr_done   = (state == UVC_DRIVE) & fall_det & cmd_reg[CMD_WRITE_BIT];
    wire rx_cap    = rise_det & ls2[8] & ls3[8];
    wire ev_done   = rd_cap | wr_done;
    wire [1:0] ev  = {rx_cap, ev_done};
    wire [1:0] w1c = (wr & hit_is) ? pwdata[1:0] : 2'h0;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign irq     = |(irq_stat & irq_mask);

    logic [31:0] read_word;

    always_comb begin
        read_word = 32'h0000_0000;
        if (hit_cmd) read_word = {15'h0000, cmd_reg};
        if (hit_rd)  read_word = {24'h00_0000, rdata_reg};
        if (hit_st)  read_word = {31'h0000_0000, busy};
        if (hit_is)  read_word = {30'h0000_0000, irq_stat};
        if (hit_im)  read_word = {30'h0000_0000, irq_mask};
        if (hit_rx)  read_word = {24'h00_0000, rxcmd_reg};
    end

    // ========================================
    // command sequencer
    always_comb begin
        next_state = state;
        case (state)
            UVC_IDLE:    if (go) next_state = UVC_ARM;
            UVC_ARM:     if (fall_det) next_state = UVC_DRIVE;
            UVC_DRIVE:   if (fall_det) next_state = cmd_reg[CMD_WRITE_BIT] ? UVC_IDLE : UVC_WAIT_RD;
            UVC_WAIT_RD: if (rd_cap) next_state = UVC_IDLE;
            default:     next_state = UVC_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= UVC_IDLE;
            cmd_reg   <= 17'h0_0000;
            rdata_reg <= 8'h00;
            rxcmd_reg <= 8'h00;
            irq_stat  <= 2'h0;
            irq_mask  <= IRQ_MASK_RESET;
            prdata    <= 32'h0000_0000;
        end else begin
            state     <= next_state;
            // read word held from setup through access
            prdata    <= (psel & ~penable & ~pwrite) ? read_word : prdata;
            cmd_reg   <= go ? pwdata[16:0] : cmd_reg;
            rdata_reg <= rd_cap ? ls3[16:9] : rdata_reg;
            rxcmd_reg <= rx_cap ? ls3[7:0] : rxcmd_reg;
            // new event wins over write-one-to-clear
            irq_stat  <= (irq_stat & ~w1c) | ev;
            irq_mask  <= (wr & hit_im) ? pwdata[1:0] : irq_mask;
        end
    end

    // link command lines, one link period wide
    assign link.cmd_valid = (state == UVC_DRIVE);
    assign link.cmd_write = cmd_reg[CMD_WRITE_BIT];
    assign link.cmd_addr  = cmd_reg[CMD_ADDR_LSB +: ADDR_W];
    assign link.cmd_wdata = cmd_reg[7:0];

endmodule // uvc_link_ctrl
`default_nettype wire

// file: uvc_link_if.sv
`default_nettype none
interface uvc_link_if;
    logic       link_clk;
    logic       cmd_valid;
    logic       cmd_write;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic       rxcmd_valid;
    logic [7:0] rxcmd_data;

    modport device (
        output link_clk, rd_valid, rd_data, rxcmd_valid, rxcmd_data,
        input  cmd_valid, cmd_write, cmd_addr, cmd_wdata
    );
    modport host (
        input  link_clk, rd_valid, rd_data, rxcmd_valid, rxcmd_data,
        output cmd_valid, cmd_write, cmd_addr, cmd_wdata
    );
endinterface
`default_nettype wire

// file: uvc_phy_regs.sv
// Local design decision: register access over the link command lines.
`default_nettype none
// Summary of operation
// - control register at 0Ah, write/set/clear.
// - bit 7 picks external indicator input.
// - bit 6 pulls power switch low.
// - bit 5 requests internal 5 V drive.
// - bit 4 charges bus, driven straight from the bit.
// - bit 3 discharges; stays set until a write or clear command clears it.
// - bit 2 minus-line pull-down, resets on.
// - bit 1 plus-line pull-down, resets on.
// - reserved bit 0 is stored as written and drives no output.
// - enabled rising source gives interrupt and report.
// - enable bits 3..0 map four sources.
// - rise enables reset to 1Fh.
// - rise enable register at 0Dh, write/set/clear.
// - session end follows its comparator.
module uvc_phy_regs
    import uvc_pkg::*;
#(
    parameter int LINK_HALF = LINK_HALF_CYC
) (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    uvc_link_if.device      link,
    input  wire logic       session_end_cmp,
    input  wire logic       session_valid_cmp,
    input  wire logic       power_valid_cmp,
    input  wire logic       host_disconnect_cmp,
    input  wire logic       fault_in,
    output logic            power_switch_out,
    output logic            power_switch_oe,
    output logic            internal_power_drive,
    output logic            bus_power_charge,
    output logic            bus_power_discharge,
    output logic            minus_line_pulldown,
    output logic            plus_line_pulldown,
    output logic [7:0]      event_status_reg,
    output logic            rise_event_irq
);

    // ========================================
    // helpers
    function automatic logic [2:0] reg_op(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] base
    );
        logic [ADDR_W-1:0] d;
        d = addr - base;
        if (d == 6'h00) begin
            reg_op = {1'b1, OP_WRITE};
        end else if (d == 6'h01) begin
            reg_op = {1'b1, OP_SET};
        end else if (d == 6'h02) begin
            reg_op = {1'b1, OP_CLEAR};
        end else begin
            reg_op = 3'h0;
        end
    endfunction

    function automatic logic [7:0] apply_op(
        input logic [7:0] cur,
        input logic [7:0] wdata,
        input logic [1:0] op
    );
        case (op)
            OP_WRITE: apply_op = wdata;
            OP_SET:   apply_op = cur | wdata;
            OP_CLEAR: apply_op = cur & ~wdata;
            default:  apply_op = cur;
        endcase
    endfunction

    function automatic logic [4:0] settle(
        input logic [4:0] lvl,
        input logic [4:0] s2,
        input logic [4:0] s3
    );
        logic [4:0] agree;
        agree  = ~(s2 ^ s3);
        settle = (agree & s2) | (~agree & lvl);
    endfunction

    // ========================================
    // link clock divider
    logic [7:0] div_cnt;
    logic       link_clk_q;
    wire        div_wrap  = (div_cnt == 8'(LINK_HALF - 1));
    wire        fall_tick = div_wrap & link_clk_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt    <= 8'h00;
            link_clk_q <= 1'b0;
        end else begin
            div_cnt    <= div_wrap ? 8'h00 : div_cnt + 8'h01;
            link_clk_q <= div_wrap ? ~link_clk_q : link_clk_q;
        end
    end

    assign link.link_clk = link_clk_q;

    // ========================================
    // synchronisers for link commands and comparators
    logic [15:0] cmd_s1;
    logic [15:0] cmd_s2;
    logic [15:0] cmd_s3;
    logic [4:0]  cmp_s1;
    logic [4:0]  cmp_s2;
    logic [4:0]  cmp_s3;
    logic [4:0]  cmp_lvl;

    wire [15:0] cmd_raw = {link.cmd_valid, link.cmd_write, link.cmd_addr, link.cmd_wdata};
    wire [4:0]  cmp_raw = {fault_in, session_end_cmp, session_valid_cmp,
                           power_valid_cmp, host_disconnect_cmp};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_s1  <= 16'h0000;
            cmd_s2  <= 16'h0000;
            cmd_s3  <= 16'h0000;
            cmp_s1  <= 5'h00;
            cmp_s2  <= 5'h00;
            cmp_s3  <= 5'h00;
            cmp_lvl <= 5'h00;
        end else begin
            cmd_s1  <= cmd_raw;
            cmd_s2  <= cmd_s1;
            cmd_s3  <= cmd_s2;
            cmp_s1  <= cmp_raw;
            cmp_s2  <= cmp_s1;
            cmp_s3  <= cmp_s2;
            cmp_lvl <= settle(cmp_lvl, cmp_s2, cmp_s3);
        end
    end

    // ========================================
    // register access decode
    logic [7:0] otg_power_control;
    logic [7:0] rise_event_enable;

    // valid counts once second and third stages agree
    wire              cmd_valid_q = cmd_s2[15] & cmd_s3[15];
    wire              cmd_write_q = cmd_s3[14];
    wire [ADDR_W-1:0] cmd_addr_q  = cmd_s3[13:8];
    wire [7:0]        cmd_data_q  = cmd_s3[7:0];
    wire              cmd_take    = fall_tick & cmd_valid_q;
    wire [2:0]        otg_dec     = reg_op(cmd_addr_q, OTG_WR_ADDR);
    wire [2:0]        rise_dec    = reg_op(cmd_addr_q, RISE_WR_ADDR);
    wire [7:0]        otg_next    = apply_op(otg_power_control, cmd_data_q, otg_dec[1:0]);
    wire [7:0]        rise_next   = apply_op(rise_event_enable, cmd_data_q, rise_dec[1:0]);
    wire              otg_wr      = cmd_take & cmd_write_q & otg_dec[2];
    wire              rise_wr     = cmd_take & cmd_write_q & rise_dec[2];
    wire [7:0]        read_mux    = otg_dec[2]  ? otg_power_control :
                                    rise_dec[2] ? rise_event_enable : 8'h00;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            otg_power_control <= OTG_RESET;
        end else if (otg_wr) begin
            otg_power_control <= otg_next;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_event_enable <= RISE_RESET;
        end else if (rise_wr) begin
            rise_event_enable <= rise_next;
        end
    end

    // ========================================
    // status sources and rising detection
    logic [NSRC-1:0] src_prev;
    logic [NSRC-1:0] pending;
    logic [NSRC-1:0] src;

    wire pwr_valid_sel = otg_power_control[EXT_IND_BIT] ? cmp_lvl[4] : cmp_lvl[1];

    always_comb begin
        src = '0;
        src[SRC_SESSION_END_SOURCE]   = cmp_lvl[3];
        src[SRC_SESS_VALID] = cmp_lvl[2];
        src[SRC_PWR_VALID]  = pwr_valid_sel;
        src[SRC_HOST_DISC]  = cmp_lvl[0];
    end

    wire [NSRC-1:0] rise_hit = src & ~src_prev & rise_event_enable[NSRC-1:0];
    wire [NSRC-1:0] reported = fall_tick ? pending : '0;
    // new edge wins over the report clear
    wire [NSRC-1:0] next_pending = (pending & ~reported) | rise_hit;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev       <= '0;
            pending        <= '0;
            rise_event_irq <= 1'b0;
        end else begin
            src_prev       <= src;
            pending        <= next_pending;
            rise_event_irq <= |rise_hit;
        end
    end

    // ========================================
    // link answers, updated on link falling edge
    logic       rd_valid_q;
    logic [7:0] rd_data_q;
    logic       rxcmd_valid_q;
    logic [7:0] rxcmd_data_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q    <= 1'b0;
            rd_data_q     <= 8'h00;
            rxcmd_valid_q <= 1'b0;
            rxcmd_data_q  <= 8'h00;
        end else if (fall_tick) begin
            rd_valid_q    <= cmd_valid_q & ~cmd_write_q;
            rd_data_q     <= read_mux;
            rxcmd_valid_q <= |pending;
            rxcmd_data_q  <= {pending, src};
        end
    end

    assign link.rd_valid    = rd_valid_q;
    assign link.rd_data     = rd_data_q;
    assign link.rxcmd_valid = rxcmd_valid_q;
    assign link.rxcmd_data  = rxcmd_data_q;

    // ========================================
    // power and resistor controls
    // open-drain switch driven low
    assign power_switch_out     = 1'b0;
    assign power_switch_oe      = otg_power_control[EXT_DRIVE_BIT];
    assign internal_power_drive = otg_power_control[INT_DRIVE_BIT];
    assign bus_power_charge     = otg_power_control[CHARGE_BIT];
    assign bus_power_discharge  = otg_power_control[DISCHARGE_BIT];
    assign minus_line_pulldown  = otg_power_control[MINUS_PD_BIT];
    assign plus_line_pulldown   = otg_power_control[PLUS_PD_BIT];
    // flopped copy of the sources
    assign event_status_reg     = {4'h0, src_prev};

endmodule // uvc_phy_regs
`default_nettype wire

// file: uvc_pkg.sv
`default_nettype none
package uvc_pkg;
    // ========================================
    // link timing
    localparam int REF_CLK_NS     = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * REF_CLK_NS);
    localparam int SYNC_STAGES    = 3;

    // ========================================
    // link widths and device register map
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam logic [5:0] OTG_WR_ADDR   = 6'h0a;
    localparam logic [5:0] RISE_WR_ADDR  = 6'h0d;
    localparam logic [1:0] OP_WRITE      = 2'h0;
    localparam logic [1:0] OP_SET        = 2'h1;
    localparam logic [1:0] OP_CLEAR      = 2'h2;
    localparam logic [7:0] OTG_RESET     = 8'h06;
    localparam logic [7:0] RISE_RESET    = 8'h1f;

    // ========================================
    // control register fields
    localparam int EXT_IND_BIT    = 7;
    localparam int EXT_DRIVE_BIT  = 6;
    localparam int INT_DRIVE_BIT  = 5;
    localparam int CHARGE_BIT     = 4;
    localparam int DISCHARGE_BIT  = 3;
    localparam int MINUS_PD_BIT   = 2;
    localparam int PLUS_PD_BIT    = 1;
    localparam int NSRC           = 4;
    // source order in status nibble and enable register
    localparam int SRC_SESSION_END_SOURCE   = 3;
    localparam int SRC_SESS_VALID = 2;
    localparam int SRC_PWR_VALID  = 1;
    localparam int SRC_HOST_DISC  = 0;

    // ========================================
    // link controller apb registers
    localparam logic [7:0] CMD_OFS      = 8'h00;
    localparam logic [7:0] RDATA_OFS    = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
    localparam logic [7:0] RXCMD_OFS    = 8'h14;
    localparam int CMD_ADDR_LSB  = 8;
    localparam int CMD_WRITE_BIT = 16;
    localparam int CMD_GO_BIT    = 31;
    localparam int IRQ_DONE_BIT  = 0;
    localparam int IRQ_RXCMD_BIT = 1;
    localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

    typedef enum logic [1:0] {
        UVC_IDLE    = 2'b00,
        UVC_ARM     = 2'b01,
        UVC_DRIVE   = 2'b11,
        UVC_WAIT_RD = 2'b10
    } uvc_state_t;
endpackage
`default_nettype wire
